// ### core/gpw_pkg.sv
// Function
// - Direction bit one makes the pin an input, zero a push-pull output.
// - Reading an output pin returns the data latch, not the pin level.
// - The output latch keeps its value until software writes it again.
// - Each input pin may enable a weak pull-high from its select bit.
// - Each port A pin is individually enabled as a wake-up source.
// - Power down lasts until a selected port A pin falls high to low.
// - Upper miscellaneous nibble makes port A pins 0 to 3 open drain.
// - External interrupts share port A pins 0 and 1 via enable bits.
// - Timer input pins stay ordinary inputs while feeding the timers.
// - Frequency output drives port A pin 3 only while set as output.
// - Pulse-width outputs drive their pins only while set as outputs.
// - Analog channel select bit makes a converter input and drops pull-high.
// - Amplifier pins on port D 3 to 5 drop pull-high when selected.
// - Reset sets every data latch and direction bit high.
// - Bit set or clear reads the whole port, changes one bit, writes back.
// - Ports give 18 or 30 lines depending on the device variant.
package gpw_pkg;
  localparam int PORT_W = 8;
  localparam int NPINS = 32;
  localparam int ADDR_W = 5;
  // Register offsets.
  localparam logic [4:0] ADDR_PA_DATA = 5'h00;
  localparam logic [4:0] ADDR_PA_DIR = 5'h01;
  localparam logic [4:0] ADDR_PB_DATA = 5'h02;
  localparam logic [4:0] ADDR_PB_DIR = 5'h03;
  localparam logic [4:0] ADDR_PC_DATA = 5'h04;
  localparam logic [4:0] ADDR_PC_DIR = 5'h05;
  localparam logic [4:0] ADDR_PD_DATA = 5'h06;
  localparam logic [4:0] ADDR_PD_DIR = 5'h07;
  localparam logic [4:0] ADDR_PA_PULL = 5'h08;
  localparam logic [4:0] ADDR_PB_PULL = 5'h09;
  localparam logic [4:0] ADDR_PC_PULL = 5'h0a;
  localparam logic [4:0] ADDR_PD_PULL = 5'h0b;
  localparam logic [4:0] ADDR_WAKE = 5'h0c;
  localparam logic [4:0] ADDR_MISC = 5'h0d;
  localparam logic [4:0] ADDR_INT_CTRL = 5'h0e;
  localparam logic [4:0] ADDR_TMRSEL = 5'h0f;
  localparam logic [4:0] ADDR_ANA0 = 5'h10;
  localparam logic [4:0] ADDR_ANA1 = 5'h11;
  localparam logic [4:0] ADDR_ANA2 = 5'h12;
  localparam logic [4:0] ADDR_CONV1 = 5'h13;
  // Reset values.
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Pins present in each variant, port A in bits 7:0 up to port D in 31:24.
  localparam logic [31:0] PIN_MASK_WIDE = 32'h3fff_ffff;
  localparam logic [31:0] PIN_MASK_NARROW = 32'h0003_ffff;
  // Field positions.
  localparam int OPEN_DRAIN_LSB = 4;
  localparam int OPEN_DRAIN_W = 4;
  localparam int EXT_INT_ZERO_EN_BIT = 1;
  localparam int EXT_INT_ONE_EN_BIT = 2;
  localparam int TIMER_ZERO_SEL_BIT = 0;
  localparam int TIMER_ONE_SEL_BIT = 1;
  localparam int AMP_SEL_LSB = 0;
  localparam int AMP_W = 3;
  // Pin positions of shared functions.
  localparam int PIN_EXT_INT_ZERO = 0;
  localparam int PIN_EXT_INT_ONE = 1;
  localparam int PIN_TIMER_ZERO = 2;
  localparam int PIN_FREQ_OUT = 3;
  localparam int PIN_PWM0 = 4;
  localparam int PIN_PWM1 = 5;
  localparam int PIN_PWM2 = 14;
  localparam int PIN_PWM3 = 15;
  localparam int PIN_TIMER_ONE = 13;
  localparam int PIN_AMP_LSB = 27;
endpackage

// ### core/gpw_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for asynchronous pin levels.
module gpw_sync #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      meta_reg <= '1;
      o_sync <= '1;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // gpw_sync
`default_nettype wire

// ### core/gpw_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
// Output and pull-high decision for one pin.
module gpw_pin_cell (
  // Configuration
  input wire logic i_present,
  input wire logic i_dir,
  input wire logic i_latch,
  input wire logic i_open_drain,
  input wire logic i_pull_sel,
  input wire logic i_analog,
  // Shared function
  input wire logic i_alt_en,
  input wire logic i_alt_val,
  // Pad controls
  output logic o_out,
  output logic o_oe,
  output logic o_pull
);
  logic val;

  always_comb begin
    val = i_alt_en ? i_alt_val : i_latch;
    o_out = val;
    o_oe = i_present & ~i_dir & ~i_analog & ~(i_open_drain & val);
    o_pull = i_present & i_dir & i_pull_sel & ~i_analog;
  end
endmodule // gpw_pin_cell
`default_nettype wire

// ### core/gpw_top.sv
`timescale 1ns/100ps
`default_nettype none
// Four bidirectional ports with wake-up, open drain and pin sharing.
module gpw_top #(
  // One selects the 30-line variant, zero the 18-line one.
  parameter bit WIDE_VARIANT = 1'b1,
  // Fixed option that routes the frequency output to its pin.
  parameter bit FREQ_OUT_OPTION = 1'b0
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_idx,
  input wire logic i_bit_val,
  output logic [7:0] o_rdata,
  // Power down
  input wire logic i_halt,
  output logic o_power_down,
  output logic o_wake,
  // Pins
  input wire logic [31:0] i_pin_in,
  output logic [31:0] o_pin_out,
  output logic [31:0] o_pin_oe,
  output logic [31:0] o_pull_high,
  // Shared functions
  input wire logic i_prog_freq_output,
  input wire logic [3:0] i_pwm_en,
  input wire logic [3:0] i_pwm_out,
  output logic o_ext_interrupt_zero,
  output logic o_ext_interrupt_one,
  output logic o_timer_zero_input,
  output logic o_timer_one_input,
  output logic [23:0] o_analog_connect,
  output logic [2:0] o_op_amp_connect
);
  localparam logic [31:0] PIN_MASK =
    WIDE_VARIANT ? gpw_pkg::PIN_MASK_WIDE : gpw_pkg::PIN_MASK_NARROW;

  logic [7:0] data_reg [4];
  logic [7:0] dir_reg [4];
  logic [7:0] pull_reg [4];
  logic [7:0] ana_reg [3];
  logic [7:0] wake_reg;
  logic [7:0] misc_reg;
  logic [7:0] intc_reg;
  logic [7:0] tmr_reg;
  logic [7:0] conv1_reg;
  logic pd_reg;
  logic [7:0] pa_prev_reg;

  logic [31:0] pin_s;
  logic [31:0] data_f;
  logic [31:0] dir_f;
  logic [31:0] pull_f;
  logic [31:0] ana_f;
  logic [31:0] od_f;
  logic [31:0] alt_en;
  logic [31:0] alt_val;
  logic [31:0] cell_out;
  logic [31:0] cell_oe;
  logic [31:0] cell_pull;
  logic [31:0] port_view;
  logic [7:0] rd_value;
  logic [7:0] wr_data;
  logic wr_en;
  logic wake_hit;
  logic pd_next;

  gpw_sync #(
    .W(32)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_async(i_pin_in),
    .o_sync(pin_s)
  );

  assign data_f = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
  assign dir_f = {dir_reg[3], dir_reg[2], dir_reg[1], dir_reg[0]};
  assign pull_f = {pull_reg[3], pull_reg[2], pull_reg[1], pull_reg[0]};

  always_comb begin
    ana_f = {8'h00, ana_reg[2], ana_reg[1], ana_reg[0]};
    for (int k = 0; k < gpw_pkg::AMP_W; k++) begin
      ana_f[gpw_pkg::PIN_AMP_LSB + k] = conv1_reg[gpw_pkg::AMP_SEL_LSB + k];
    end
  end

  always_comb begin
    od_f = 32'h0000_0000;
    od_f[gpw_pkg::OPEN_DRAIN_W-1:0] =
      misc_reg[gpw_pkg::OPEN_DRAIN_LSB +: gpw_pkg::OPEN_DRAIN_W];
  end

  // Shared outputs replace the latch whenever enabled; the pad drives them only while the pin is an output.
  always_comb begin
    alt_en = 32'h0000_0000;
    alt_val = 32'h0000_0000;
    alt_en[gpw_pkg::PIN_FREQ_OUT] = FREQ_OUT_OPTION;
    alt_val[gpw_pkg::PIN_FREQ_OUT] = i_prog_freq_output;
    alt_en[gpw_pkg::PIN_PWM0] = i_pwm_en[0];
    alt_val[gpw_pkg::PIN_PWM0] = i_pwm_out[0];
    alt_en[gpw_pkg::PIN_PWM1] = i_pwm_en[1];
    alt_val[gpw_pkg::PIN_PWM1] = i_pwm_out[1];
    alt_en[gpw_pkg::PIN_PWM2] = i_pwm_en[2];
    alt_val[gpw_pkg::PIN_PWM2] = i_pwm_out[2];
    alt_en[gpw_pkg::PIN_PWM3] = i_pwm_en[3];
    alt_val[gpw_pkg::PIN_PWM3] = i_pwm_out[3];
  end

  genvar g;
  generate
    for (g = 0; g < gpw_pkg::NPINS; g++) begin : g_pin
      gpw_pin_cell u_cell (
        .i_present(PIN_MASK[g]),
        .i_dir(dir_f[g]),
        .i_latch(data_f[g]),
        .i_open_drain(od_f[g]),
        .i_pull_sel(pull_f[g]),
        .i_analog(ana_f[g]),
        .i_alt_en(alt_en[g]),
        .i_alt_val(alt_val[g]),
        .o_out(cell_out[g]),
        .o_oe(cell_oe[g]),
        .o_pull(cell_pull[g])
      );
    end
  endgenerate

  assign port_view = ((dir_f & pin_s) | (~dir_f & data_f)) & PIN_MASK;

  always_comb begin
    rd_value = 8'h00;
    unique case (i_addr)
      gpw_pkg::ADDR_PA_DATA: rd_value = port_view[7:0];
      gpw_pkg::ADDR_PB_DATA: rd_value = port_view[15:8];
      gpw_pkg::ADDR_PC_DATA: rd_value = port_view[23:16];
      gpw_pkg::ADDR_PD_DATA: rd_value = port_view[31:24];
      gpw_pkg::ADDR_PA_DIR: rd_value = dir_reg[0];
      gpw_pkg::ADDR_PB_DIR: rd_value = dir_reg[1];
      gpw_pkg::ADDR_PC_DIR: rd_value = dir_reg[2];
      gpw_pkg::ADDR_PD_DIR: rd_value = dir_reg[3];
      gpw_pkg::ADDR_PA_PULL: rd_value = pull_reg[0];
      gpw_pkg::ADDR_PB_PULL: rd_value = pull_reg[1];
      gpw_pkg::ADDR_PC_PULL: rd_value = pull_reg[2];
      gpw_pkg::ADDR_PD_PULL: rd_value = pull_reg[3];
      gpw_pkg::ADDR_WAKE: rd_value = wake_reg;
      gpw_pkg::ADDR_MISC: rd_value = misc_reg;
      gpw_pkg::ADDR_INT_CTRL: rd_value = intc_reg;
      gpw_pkg::ADDR_TMRSEL: rd_value = tmr_reg;
      gpw_pkg::ADDR_ANA0: rd_value = ana_reg[0];
      gpw_pkg::ADDR_ANA1: rd_value = ana_reg[1];
      gpw_pkg::ADDR_ANA2: rd_value = ana_reg[2];
      gpw_pkg::ADDR_CONV1: rd_value = conv1_reg;
      default: rd_value = 8'h00;
    endcase
  end

  // read-modify-write
  // An input pin's live level is written back into its latch, as on the part.
  always_comb begin
    wr_data = i_wdata;
    if (i_bit_wr) begin
      wr_data = rd_value;
      wr_data[i_bit_idx] = i_bit_val;
    end
  end

  assign wr_en = i_wr | i_bit_wr;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      for (int p = 0; p < 4; p++) begin
        data_reg[p] <= gpw_pkg::PORT_RST;
      end
    end else if (wr_en) begin
      unique case (i_addr)
        gpw_pkg::ADDR_PA_DATA: data_reg[0] <= wr_data;
        gpw_pkg::ADDR_PB_DATA: data_reg[1] <= wr_data;
        gpw_pkg::ADDR_PC_DATA: data_reg[2] <= wr_data;
        gpw_pkg::ADDR_PD_DATA: data_reg[3] <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      for (int p = 0; p < 4; p++) begin
        dir_reg[p] <= gpw_pkg::PORT_RST;
      end
    end else if (wr_en) begin
      unique case (i_addr)
        gpw_pkg::ADDR_PA_DIR: dir_reg[0] <= wr_data;
        gpw_pkg::ADDR_PB_DIR: dir_reg[1] <= wr_data;
        gpw_pkg::ADDR_PC_DIR: dir_reg[2] <= wr_data;
        gpw_pkg::ADDR_PD_DIR: dir_reg[3] <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      for (int p = 0; p < 4; p++) begin
        pull_reg[p] <= gpw_pkg::CTRL_RST;
      end
    end else if (wr_en) begin
      unique case (i_addr)
        gpw_pkg::ADDR_PA_PULL: pull_reg[0] <= wr_data;
        gpw_pkg::ADDR_PB_PULL: pull_reg[1] <= wr_data;
        gpw_pkg::ADDR_PC_PULL: pull_reg[2] <= wr_data;
        gpw_pkg::ADDR_PD_PULL: pull_reg[3] <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wake_reg <= gpw_pkg::CTRL_RST;
    end else if (wr_en && i_addr == gpw_pkg::ADDR_WAKE) begin
      wake_reg <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      misc_reg <= gpw_pkg::CTRL_RST;
    end else if (wr_en && i_addr == gpw_pkg::ADDR_MISC) begin
      misc_reg <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      intc_reg <= gpw_pkg::CTRL_RST;
    end else if (wr_en && i_addr == gpw_pkg::ADDR_INT_CTRL) begin
      intc_reg <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      tmr_reg <= gpw_pkg::CTRL_RST;
    end else if (wr_en && i_addr == gpw_pkg::ADDR_TMRSEL) begin
      tmr_reg <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      for (int a = 0; a < 3; a++) begin
        ana_reg[a] <= gpw_pkg::CTRL_RST;
      end
    end else if (wr_en) begin
      unique case (i_addr)
        gpw_pkg::ADDR_ANA0: ana_reg[0] <= wr_data;
        gpw_pkg::ADDR_ANA1: ana_reg[1] <= wr_data;
        gpw_pkg::ADDR_ANA2: ana_reg[2] <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      conv1_reg <= gpw_pkg::CTRL_RST;
    end else if (wr_en && i_addr == gpw_pkg::ADDR_CONV1) begin
      conv1_reg <= wr_data;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_value;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // falling edge on a selected port A pin
  assign wake_hit = |(wake_reg & pa_prev_reg & ~pin_s[7:0]);
  // A halt in the same cycle as a wake edge still enters power down.
  assign pd_next = i_halt | (pd_reg & ~wake_hit);

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pa_prev_reg <= gpw_pkg::PORT_RST;
      pd_reg <= 1'b0;
      o_power_down <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      pa_prev_reg <= pin_s[7:0];
      pd_reg <= pd_next;
      o_power_down <= pd_next;
      o_wake <= pd_reg & wake_hit & ~i_halt;
    end
  end

  // Pad controls are registered so that no pad sees a decode glitch.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_pin_out <= 32'h0000_0000;
      o_pin_oe <= 32'h0000_0000;
      o_pull_high <= 32'h0000_0000;
      o_analog_connect <= 24'h00_0000;
      o_op_amp_connect <= 3'h0;
    end else begin
      o_pin_out <= cell_out & PIN_MASK;
      o_pin_oe <= cell_oe;
      o_pull_high <= cell_pull;
      o_analog_connect <= ana_f[23:0] & PIN_MASK[23:0];
      o_op_amp_connect <= ana_f[gpw_pkg::PIN_AMP_LSB +: gpw_pkg::AMP_W]
        & PIN_MASK[gpw_pkg::PIN_AMP_LSB +: gpw_pkg::AMP_W];
    end
  end

  // Shared inputs keep the ordinary read path alive at the same time.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_ext_interrupt_zero <= 1'b0;
      o_ext_interrupt_one <= 1'b0;
      o_timer_zero_input <= 1'b0;
      o_timer_one_input <= 1'b0;
    end else begin
      o_ext_interrupt_zero <= intc_reg[gpw_pkg::EXT_INT_ZERO_EN_BIT]
        & pin_s[gpw_pkg::PIN_EXT_INT_ZERO];
      o_ext_interrupt_one <= intc_reg[gpw_pkg::EXT_INT_ONE_EN_BIT]
        & pin_s[gpw_pkg::PIN_EXT_INT_ONE];
      o_timer_zero_input <= tmr_reg[gpw_pkg::TIMER_ZERO_SEL_BIT]
        & dir_f[gpw_pkg::PIN_TIMER_ZERO] & pin_s[gpw_pkg::PIN_TIMER_ZERO];
      o_timer_one_input <= tmr_reg[gpw_pkg::TIMER_ONE_SEL_BIT]
        & dir_f[gpw_pkg::PIN_TIMER_ONE] & pin_s[gpw_pkg::PIN_TIMER_ONE];
    end
  end
endmodule // gpw_top
`default_nettype wire

// ### verification/gpw_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module gpw_checker #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Watched ports
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_halt,
  input wire logic o_power_down,
  input wire logic o_wake,
  input wire logic [31:0] o_pin_oe,
  input wire logic [31:0] o_pull_high,
  input wire logic [23:0] o_analog_connect,
  input wire logic [2:0] o_op_amp_connect
);
  localparam logic [31:0] PIN_MASK =
    WIDE_VARIANT ? gpw_pkg::PIN_MASK_WIDE : gpw_pkg::PIN_MASK_NARROW;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  chk_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_out_no_pull: assert property ((o_pin_oe & o_pull_high) == 32'h0)
    else $error("pull-high on a driven pin");
  chk_analog_free: assert property (
    (o_analog_connect & (o_pull_high[23:0] | o_pin_oe[23:0])) == 24'h0)
    else $error("converter pin driven or pulled");
  chk_amp_no_pull: assert property ((o_op_amp_connect & o_pull_high[29:27]) == 3'h0)
    else $error("pull-high on an amplifier pin");
  chk_absent_pins: assert property (((o_pin_oe | o_pull_high) & ~PIN_MASK) == 32'h0)
    else $error("absent pin is active");
  chk_halt_enter: assert property (i_halt |=> o_power_down)
    else $error("halt did not enter power down");
  chk_sleep_cause: assert property ($rose(o_power_down) |-> $past(i_halt))
    else $error("power down without halt");
  chk_stay_asleep: assert property ($fell(o_power_down) |-> o_wake)
    else $error("power down left without wake");
  chk_wake_only: assert property (o_wake |-> $past(o_power_down) && !o_power_down)
    else $error("wake while not powered down");
  chk_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake pulse too long");
  chk_reset_inputs: assert property ($rose(i_resetn) |-> o_pin_oe == 32'h0)
    else $error("pins driven after reset");
  cover property (o_wake);
  cover property (i_halt);
  cover property (|o_pin_oe);
endmodule // gpw_checker
bind gpw_top gpw_checker #(.WIDE_VARIANT(WIDE_VARIANT)) gpw_checker_i (.i_ref_clk, .i_resetn,
  .i_rd, .o_rdata, .i_halt, .o_power_down, .o_wake, .o_pin_oe, .o_pull_high,
  .o_analog_connect, .o_op_amp_connect);
`default_nettype wire

// ### verification/gpw_board.sv
`timescale 1ns/100ps
`default_nettype none
module gpw_board (
  // Clock
  input wire logic i_ref_clk,
  // Pads from the port
  input wire logic [31:0] i_pin_out,
  input wire logic [31:0] i_pin_oe,
  input wire logic [31:0] i_pull_high,
  // Outside drivers
  input wire logic [31:0] i_ext_en,
  input wire logic [31:0] i_ext_val,
  // Resolved pad levels
  output logic [31:0] o_level
);
  logic [31:0] float_reg = 32'h5555_5555;
  // A floating pad wanders, so the port can never lean on its last level.
  always @(posedge i_ref_clk) begin
    float_reg <= ~float_reg;
  end
  // outside level held steady, else drive, pull-high or float
  assign o_level = (i_ext_en & i_ext_val) | (~i_ext_en & i_pin_oe & i_pin_out) |
    (~i_ext_en & ~i_pin_oe & (i_pull_high | float_reg));
endmodule // gpw_board
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_bit_wr = 1'b0;
  logic [2:0] i_bit_idx = 3'h0;
  logic i_bit_val = 1'b0;
  logic i_halt = 1'b0;
  logic i_prog_freq_output = 1'b0;
  logic [3:0] i_pwm_en = 4'h0;
  logic [3:0] i_pwm_out = 4'h0;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] i_pin_in;
  logic [7:0] o_rdata;
  logic o_power_down;
  logic o_wake;
  logic o_ext_interrupt_zero;
  logic o_ext_interrupt_one;
  logic o_timer_zero_input;
  logic o_timer_one_input;
  logic [31:0] o_pin_out;
  logic [31:0] o_pin_oe;
  logic [31:0] o_pull_high;
  logic [23:0] o_analog_connect;
  logic [2:0] o_op_amp_connect;
  int num_errors = 0;
  int samples_checked = 0;
  int cycle_count = 0;
  int n;
  always #5 i_ref_clk = ~i_ref_clk;
  gpw_top #(.WIDE_VARIANT(1'b1), .FREQ_OUT_OPTION(1'b1)) gpw_top_i (.i_ref_clk, .i_resetn,
    .i_addr, .i_wdata, .i_wr, .i_rd, .i_bit_wr, .i_bit_idx, .i_bit_val, .o_rdata,
    .i_halt, .o_power_down, .o_wake, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pull_high,
    .i_prog_freq_output, .i_pwm_en, .i_pwm_out, .o_ext_interrupt_zero,
    .o_ext_interrupt_one, .o_timer_zero_input, .o_timer_one_input,
    .o_analog_connect, .o_op_amp_connect);
  gpw_board gpw_board_i (.i_ref_clk, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pull_high(o_pull_high), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pin_in));
  task automatic end_of_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(32'(o_rdata), 32'(e));
  endtask
  // Pads follow a register one edge later and inputs pass two flops.
  task automatic settle;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  always @(posedge i_ref_clk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(gpw_pkg::ADDR_PA_DIR, 8'hff);
    rd(gpw_pkg::ADDR_PD_DIR, 8'hff);
    rd(5'h1f, 8'h00);
    wr(gpw_pkg::ADDR_PA_PULL, 8'hff);
    settle;
    chk(o_pull_high, 32'h0000_00ff);
    wr(gpw_pkg::ADDR_PA_DIR, 8'hf0);
    settle;
    chk(o_pin_oe, 32'h0000_000f);
    chk(32'(o_pin_out[2:0]), 32'h7);
    chk(32'(o_pin_out[3]), 32'h0);
    chk(o_pull_high, 32'h0000_00f0);
    ext_en <= 32'h0000_00ff;
    ext_val <= 32'h0000_003c;
    wr(gpw_pkg::ADDR_PA_DATA, 8'ha5);
    wr(gpw_pkg::ADDR_PB_DATA, 8'h00);
    settle;
    rd(gpw_pkg::ADDR_PA_DATA, 8'h35);
    chk(32'(o_pin_out[3:0]), 32'h5);
    wr(gpw_pkg::ADDR_MISC, 8'h10);
    settle;
    chk(o_pin_oe, 32'h0000_000e);
    wr(gpw_pkg::ADDR_PA_DATA, 8'ha4);
    settle;
    chk(o_pin_oe, 32'h0000_000f);
    @(posedge i_ref_clk);
    i_addr <= gpw_pkg::ADDR_PA_DATA;
    i_bit_idx <= 3'h6;
    i_bit_val <= 1'b1;
    i_bit_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_bit_wr <= 1'b0;
    wr(gpw_pkg::ADDR_PA_DIR, 8'h00);
    settle;
    chk(32'(o_pin_out[7:0]), 32'h74);
    @(posedge i_ref_clk);
    i_pwm_en <= 4'h1;
    i_prog_freq_output <= 1'b1;
    settle;
    chk(32'(o_pin_out[4:3]), 32'h1);
    wr(gpw_pkg::ADDR_PA_DIR, 8'h18);
    settle;
    chk(32'({o_pin_oe[4:3], o_pull_high[4:3]}), 32'h3);
    wr(gpw_pkg::ADDR_PA_DIR, 8'hff);
    ext_en <= 32'h0000_20ff;
    ext_val <= 32'h0000_2007;
    wr(gpw_pkg::ADDR_INT_CTRL, 8'h06);
    wr(gpw_pkg::ADDR_TMRSEL, 8'h03);
    settle;
    chk(32'({o_ext_interrupt_zero, o_ext_interrupt_one}), 32'h3);
    chk(32'({o_timer_zero_input, o_timer_one_input}), 32'h3);
    rd(gpw_pkg::ADDR_PA_DATA, 8'h07);
    wr(gpw_pkg::ADDR_INT_CTRL, 8'h00);
    settle;
    chk(32'({o_ext_interrupt_zero, o_ext_interrupt_one}), 32'h0);
    wr(gpw_pkg::ADDR_ANA0, 8'h80);
    settle;
    chk(32'({o_analog_connect[7], o_pull_high[7]}), 32'h2);
    wr(gpw_pkg::ADDR_PD_PULL, 8'hff);
    wr(gpw_pkg::ADDR_CONV1, 8'h07);
    settle;
    chk(32'({o_op_amp_connect, o_pull_high[31:24]}), 32'h707);
    ext_val <= 32'h0000_00ff;
    wr(gpw_pkg::ADDR_WAKE, 8'h02);
    settle;
    @(posedge i_ref_clk);
    i_halt <= 1'b1;
    @(posedge i_ref_clk);
    i_halt <= 1'b0;
    #1 chk(32'(o_power_down), 32'h1);
    ext_val <= 32'h0000_00fe;
    settle;
    settle;
    chk(32'({o_power_down, o_wake}), 32'h2);
    ext_val <= 32'h0000_00fc;
    n = 0;
    while (o_wake !== 1'b1 && n < 10) begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    chk(32'({o_wake, o_power_down}), 32'h2);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
